//--- pwm_map.svh
// Register map, field positions and reset values of the timer based PWM unit
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH

`define OFS_MODULE_CONTROL 8'h00
`define OFS_PERIOD_LIMIT   8'h04
`define OFS_TIMER_CONTROL  8'h08
`define OFS_TIMER_COUNT    8'h0c
`define OFS_DUTY_HIGH      8'h10
`define OFS_DUTY_SHADOW    8'h14
`define OFS_STATUS         8'h18
`define OFS_PIN_DIRECTION  8'h1c
`define OFS_STEERING       8'h20

`define RST_BYTE           8'h00
`define RST_PIN_DIRECTION  2'h3
`define RST_STEERING       2'h1

`define MC_OUT_MODE_HI     7
`define MC_OUT_MODE_LO     6
`define MC_DUTY_LOW_HI     5
`define MC_DUTY_LOW_LO     4
`define MC_MODE_HI         3
`define MC_MODE_LO         0
`define MC_PWM_BITS        2'h3
`define TC_POST_HI         6
`define TC_POST_LO         3
`define TC_RUN_BIT         2
`define TC_PRE_HI          1
`define TC_PRE_LO          0
`define PRE_DIV1           2'h0
`define PRE_DIV4           2'h1
`define OUT_SINGLE         2'h0
`define OUT_HALF_BRIDGE    2'h2
`define QUARTER_LAST       2'h3

`endif

//--- pwm_pkg.sv
// Types shared by the timer based PWM unit
package pwm_pkg;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } start_state_type;

    typedef struct packed {
        logic b_oe;
        logic b;
        logic a_oe;
        logic a;
    } pwm_pins_type;

    typedef struct packed {
        logic [1:0] out_mode;
        logic [1:0] duty_low;
        logic [3:0] mode;
    } module_control_type;

endpackage : pwm_pkg

//--- timer_based_pwm_unit.sv
// Timer based PWM unit with APB register access
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "pwm_map.svh"

module timer_based_pwm_unit
    import pwm_pkg::*;
(
    input  wire logic         ref_clk_in,
    input  wire logic         reset_n_in,
    input  wire logic         psel_in,
    input  wire logic         penable_in,
    input  wire logic         pwrite_in,
    input  wire logic [7:0]   paddr_in,
    input  wire logic [31:0]  pwdata_in,
    input  wire logic         sleep_in,
    output logic [31:0]       prdata_out,
    output logic              pready_out,
    output logic              pslverr_out,
    output pwm_pins_type      pins_out,
    output logic              timer_match_flag_out
);

    // Low two time base bits: oscillator phase at 1:1, else prescaler bits
    function automatic logic [1:0] base_low(input logic [1:0] sel,
                                            input logic [1:0] phase,
                                            input logic [3:0] pre);
        if (sel == `PRE_DIV1) begin
            base_low = phase;
        end else if (sel == `PRE_DIV4) begin
            base_low = pre[1:0];
        end else begin
            base_low = pre[3:2];
        end
    endfunction : base_low

    module_control_type mc_q;
    logic [7:0]         period_limit_q;
    logic [7:0]         timer_control_q;
    logic [7:0]         period_timer_count_q;
    logic [7:0]         duty_high_bits_reg_q;
    logic [7:0]         duty_shadow_reg_q;
    logic [1:0]         duty_latch_q;
    logic [1:0]         pin_direction_q;
    logic [1:0]         steering_q;
    logic               timer_match_flag_q;
    logic               sleep_meta_q;
    logic               sleep_q;
    logic [1:0]         phase_q;
    logic [3:0]         pre_q;
    logic               raw_q;
    logic               start_q;
    start_state_type    state_q;
    pwm_pins_type       pins_q;
    pwm_pins_type       pins_d;
    logic               pready_q;
    logic               pslverr_q;
    logic [31:0]        prdata_q;
    logic [31:0]        rdata_d;
    logic               addr_ok;
    logic               wr;
    logic               wr_clear_flag;
    logic               pwm_en;
    logic               timer_run;
    logic [1:0]         pre_sel;
    logic               pre_term;
    logic               tmr_inc;
    logic               wrap;
    logic [9:0]         time_base;
    logic [9:0]         duty_new;
    logic               half_bridge;
    logic               single;
    logic               drive_a;
    logic               drive_b;

    // Sleep request arrives from outside this clock's logic
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            sleep_meta_q <= 1'b0;
            sleep_q      <= 1'b0;
        end else begin
            sleep_meta_q <= sleep_in;
            sleep_q      <= sleep_meta_q;
        end
    end

    assign wr            = psel_in & penable_in & pready_q & pwrite_in;
    assign pwm_en        = (mc_q.mode[`MC_MODE_HI:2] == `MC_PWM_BITS);
    assign timer_run     = timer_control_q[`TC_RUN_BIT];
    assign pre_sel       = timer_control_q[`TC_PRE_HI:`TC_PRE_LO];
    assign wr_clear_flag = wr & (paddr_in == `OFS_STATUS) & pwdata_in[0];

    // Prescale 1, 4 or 16 instruction cycles per timer step
    always_comb begin
        if (pre_sel == `PRE_DIV1) begin
            pre_term = 1'b1;
        end else if (pre_sel == `PRE_DIV4) begin
            pre_term = (pre_q[1:0] == 2'h3);
        end else begin
            pre_term = (pre_q == 4'hf);
        end
    end

    // Postscale field is stored only and never gates the timer
    assign tmr_inc = timer_run & ~sleep_q & (phase_q == `QUARTER_LAST) & pre_term;
    assign wrap    = tmr_inc & (period_timer_count_q == period_limit_q);
    assign duty_new = {duty_high_bits_reg_q, mc_q.duty_low};
    assign time_base = {period_timer_count_q,
                        base_low(pre_sel, phase_q, pre_q)};

    // Four oscillator clocks per instruction cycle, frozen in sleep
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            phase_q <= 2'h0;
        end else if (!sleep_q) begin
            phase_q <= phase_q + 2'h1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            pre_q <= 4'h0;
        end else if (wr && paddr_in == `OFS_TIMER_COUNT) begin
            pre_q <= 4'h0;
        end else if (timer_run && !sleep_q && phase_q == `QUARTER_LAST) begin
            pre_q <= pre_term ? 4'h0 : pre_q + 4'h1;
        end
    end

    // Period timer: wraps to zero on the step after the limit match
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            period_timer_count_q <= `RST_BYTE;
        end else if (wr && paddr_in == `OFS_TIMER_COUNT) begin
            period_timer_count_q <= pwdata_in[7:0];
        end else if (wrap) begin
            period_timer_count_q <= `RST_BYTE;
        end else if (tmr_inc) begin
            period_timer_count_q <= period_timer_count_q + 8'h01;
        end
    end

    // Set wins over a clearing write in the same cycle
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            timer_match_flag_q <= 1'b0;
        end else if (wrap) begin
            timer_match_flag_q <= 1'b1;
        end else if (wr_clear_flag) begin
            timer_match_flag_q <= 1'b0;
        end
    end

    // Software registers
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            mc_q                 <= `RST_BYTE;
            period_limit_q       <= `RST_BYTE;
            timer_control_q      <= `RST_BYTE;
            duty_high_bits_reg_q <= `RST_BYTE;
            pin_direction_q      <= `RST_PIN_DIRECTION;
            steering_q           <= `RST_STEERING;
        end else if (wr) begin
            // Duty fields accepted at any time, used only at wrap
            case (paddr_in)
                `OFS_MODULE_CONTROL: begin
                    mc_q <= pwdata_in[7:0];
                end
                `OFS_PERIOD_LIMIT: begin
                    period_limit_q <= pwdata_in[7:0];
                end
                `OFS_TIMER_CONTROL: begin
                    timer_control_q <= {1'b0, pwdata_in[6:0]};
                end
                `OFS_DUTY_HIGH: begin
                    duty_high_bits_reg_q <= pwdata_in[7:0];
                end
                `OFS_PIN_DIRECTION: begin
                    pin_direction_q <= pwdata_in[1:0];
                end
                `OFS_STEERING: begin
                    steering_q <= pwdata_in[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Shadow duty and hidden two-bit latch double-buffer the duty
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            duty_shadow_reg_q <= `RST_BYTE;
            duty_latch_q      <= 2'h0;
        end else if (wrap) begin
            duty_shadow_reg_q <= duty_new[9:2];
            duty_latch_q      <= duty_new[1:0];
        end else if (wr && !pwm_en && paddr_in == `OFS_DUTY_SHADOW) begin
            duty_shadow_reg_q <= pwdata_in[7:0];
        end
    end

    // Start-up: wait for a period boundary after first enable
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            state_q <= ST_OFF;
        end else begin
            case (state_q)
                ST_OFF: begin
                    if (pwm_en) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!pwm_en) begin
                        state_q <= ST_OFF;
                    end else if (wrap) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!pwm_en) begin
                        state_q <= ST_OFF;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    // Set lags the wrap by one clock like the registered clear, so high time is exactly duty steps
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            start_q <= 1'b0;
        end else if (!sleep_q) begin
            start_q <= wrap && (state_q != ST_OFF);
        end
    end

    // Waveform: set at period start, cleared on time base match
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            raw_q <= 1'b0;
        end else if (!pwm_en) begin
            raw_q <= 1'b0;
        end else if (sleep_q) begin
            raw_q <= raw_q;
        end else if (start_q) begin
            raw_q <= ({duty_shadow_reg_q, duty_latch_q} != 10'h000);
        end else if (state_q == ST_RUN &&
                     time_base == {duty_shadow_reg_q, duty_latch_q}) begin
            raw_q <= 1'b0;
        end
        // No match inside the period leaves the level as it is
    end

    assign half_bridge = (mc_q.out_mode == `OUT_HALF_BRIDGE);
    assign single      = (mc_q.out_mode == `OUT_SINGLE);
    // Pins outside the selected mode stay unclaimed
    assign drive_a = pwm_en & (half_bridge | (single & steering_q[0]));
    assign drive_b = pwm_en & (half_bridge | (single & steering_q[1]));

    always_comb begin
        pins_d.a    = raw_q ^ mc_q.mode[1];
        pins_d.b    = (half_bridge ? ~raw_q : raw_q) ^ mc_q.mode[0];
        // Enable needs the pin direction bit cleared
        pins_d.a_oe = drive_a & ~pin_direction_q[0];
        pins_d.b_oe = drive_b & ~pin_direction_q[1];
        if (mc_q == `RST_BYTE) begin
            pins_d = '0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            pins_q <= '0;
        end else if (!sleep_q || mc_q == `RST_BYTE) begin
            pins_q <= pins_d;
        end
    end

    // APB read decode
    always_comb begin
        rdata_d = 32'h0000_0000;
        addr_ok = 1'b1;
        case (paddr_in)
            `OFS_MODULE_CONTROL: rdata_d[7:0] = mc_q;
            `OFS_PERIOD_LIMIT:   rdata_d[7:0] = period_limit_q;
            `OFS_TIMER_CONTROL:  rdata_d[7:0] = timer_control_q;
            `OFS_TIMER_COUNT:    rdata_d[7:0] = period_timer_count_q;
            `OFS_DUTY_HIGH:      rdata_d[7:0] = duty_high_bits_reg_q;
            `OFS_DUTY_SHADOW:    rdata_d[7:0] = duty_shadow_reg_q;
            `OFS_STATUS:         rdata_d[0]   = timer_match_flag_q;
            `OFS_PIN_DIRECTION:  rdata_d[1:0] = pin_direction_q;
            `OFS_STEERING:       rdata_d[1:0] = steering_q;
            default:             addr_ok      = 1'b0;
        endcase
    end

    // No wait state: pready rises in the first access cycle
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel_in & ~penable_in;
            pslverr_q <= psel_in & ~penable_in & ~addr_ok;
            prdata_q  <= (psel_in && !penable_in && !pwrite_in) ? rdata_d : 32'h0000_0000;
        end
    end

    assign prdata_out           = prdata_q;
    assign pready_out           = pready_q;
    assign pslverr_out          = pslverr_q;
    assign pins_out             = pins_q;
    assign timer_match_flag_out = timer_match_flag_q;

endmodule : timer_based_pwm_unit

//--- timer_based_pwm_unit_properties.sv
// Port-level assertions for the timer based PWM unit
`timescale 1ns/1ps
module timer_based_pwm_unit_checker
    import pwm_pkg::*;
(
    input wire logic         ref_clk_in,
    input wire logic         reset_n_in,
    input wire logic         psel_in,
    input wire logic         penable_in,
    input wire logic         pwrite_in,
    input wire logic [7:0]   paddr_in,
    input wire logic [31:0]  pwdata_in,
    input wire logic         sleep_in,
    input wire logic [31:0]  prdata_out,
    input wire logic         pready_out,
    input wire logic         pslverr_out,
    input wire pwm_pins_type pins_out,
    input wire logic         timer_match_flag_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    wire logic wr_acc = psel_in && penable_in && pwrite_in && pready_out;
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_answer;
        pready_out ##1 !pready_out;
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0)
        !reset_n_in |=> pins_out == 4'h0 && !timer_match_flag_out) else $error("outputs active after reset");
    a_ready_timing: assert property (s_setup |=> s_answer)
        else $error("ready not a single pulse after setup");
    a_err_unmapped: assert property (pready_out && paddr_in > 8'h20 |-> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (pready_out && paddr_in < 8'h24 && paddr_in[1:0] == 2'h0 |-> !pslverr_out)
        else $error("mapped access refused");
    a_idle_quiet: assert property (!pready_out |-> prdata_out == 32'h0 && !pslverr_out)
        else $error("read data outside answer");
    a_sleep_freeze: assert property ((sleep_in && !psel_in)[*6] |-> $stable(pins_out))
        else $error("pins moved in sleep");
    a_flag_sticky: assert property ($fell(timer_match_flag_out) |->
        $past(wr_acc) || $past(wr_acc, 2) || !$past(reset_n_in)) else $error("flag dropped by itself");
    a_zero_release: assert property (wr_acc && paddr_in == 8'h00 && pwdata_in[7:0] == 8'h00 |->
        ##[1:2] (!pins_out.a_oe && !pins_out.b_oe)) else $error("pins kept after control cleared");
endmodule : timer_based_pwm_unit_checker

bind timer_based_pwm_unit timer_based_pwm_unit_checker timer_based_pwm_unit_checker_i (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .sleep_in(sleep_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .pins_out(pins_out),
    .timer_match_flag_out(timer_match_flag_out));

//--- pwm_load.sv
// Load on the PWM pins: pull-down wires and a pulse timing monitor
`timescale 1ns/1ps
module pwm_load
    import pwm_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire pwm_pins_type pins_in,
    output logic              level_a_out,
    output logic              level_b_out,
    output logic [15:0]       high_len_out,
    output logic [15:0]       period_len_out,
    output logic [7:0]        rises_out
);
    logic        prev_q;
    logic [15:0] cnt_q;
    logic [15:0] hi_q;
    // A released pin falls to the pull-down level
    assign level_a_out = pins_in.a_oe ? pins_in.a : 1'b0;
    assign level_b_out = pins_in.b_oe ? pins_in.b : 1'b0;
    // Each rising edge on pin A closes one period and its high time
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            prev_q <= 1'b0;
            cnt_q <= 16'h0000;
            hi_q <= 16'h0000;
            rises_out <= 8'h00;
            high_len_out <= 16'h0000;
            period_len_out <= 16'h0000;
        end else begin
            prev_q <= level_a_out;
            if (level_a_out && !prev_q) begin
                period_len_out <= cnt_q;
                high_len_out <= hi_q;
                rises_out <= rises_out + 8'h01;
                cnt_q <= 16'h0001;
                hi_q <= 16'h0001;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
                hi_q <= hi_q + {15'h0000, level_a_out};
            end
        end
    end
endmodule : pwm_load

//--- timer_based_pwm_unit_test.sv
// Self-checking bench for the timer based PWM unit
`timescale 1ns/1ps
`include "pwm_map.svh"
module timer_based_pwm_unit_test;
    logic clk, rst_n, psel, penable, pwrite, sleep, pready, pslverr, flag, lvl_a, lvl_b, err;
    logic [7:0] paddr, rises;
    logic [31:0] pwdata, prdata, rd, c1;
    logic [15:0] hi_len, per_len;
    pwm_pkg::pwm_pins_type pins;
    int err_total, n_checks, i;
    timer_based_pwm_unit timer_based_pwm_unit_i (.ref_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .sleep_in(sleep),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .pins_out(pins),
        .timer_match_flag_out(flag));
    pwm_load pwm_load_i (.clk_in(clk), .rst_n_in(rst_n), .pins_in(pins), .level_a_out(lvl_a),
        .level_b_out(lvl_b), .high_len_out(hi_len), .period_len_out(per_len), .rises_out(rises));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 16) check(1'b0, 1'b1);
        if (k == 16) wrap_up;
    endtask : apb
    task automatic rdc(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(rd, exp);
    endtask : rdc
    task automatic wait_rises(input logic [7:0] n);
        int k;
        logic [7:0] r0;
        r0 = rises;
        for (k = 0; k < 2000 && 8'(rises - r0) < n; k++) @(posedge clk);
        if (k == 2000) check(1'b0, 1'b1);
        if (k == 2000) wrap_up;
    endtask : wait_rises
    initial begin
        {err_total, n_checks} = 0;
        {rst_n, psel, penable, pwrite, sleep, paddr, pwdata} = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 9; i++) rdc(8'(i * 4), i == 7 ? 32'h3 : i == 8 ? 32'h1 : 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check(err, 1'b1);
        apb(1'b1, `OFS_PIN_DIRECTION, 32'h3);
        apb(1'b1, `OFS_PERIOD_LIMIT, 32'h3);
        rdc(`OFS_PERIOD_LIMIT, 32'h3);
        apb(1'b1, `OFS_MODULE_CONTROL, 32'h0c);
        apb(1'b1, `OFS_DUTY_HIGH, 32'h2);
        apb(1'b1, `OFS_STATUS, 32'h1);
        apb(1'b1, `OFS_TIMER_CONTROL, 32'h4);
        for (i = 0; i < 200 && flag !== 1'b1; i++) @(posedge clk);
        check(flag, 1'b1);
        if (flag !== 1'b1) wrap_up;
        apb(1'b1, `OFS_PIN_DIRECTION, 32'h0);
        wait_rises(3);
        check({per_len, hi_len}, {16'd16, 16'd8});
        check(pins.b_oe, 1'b0);
        apb(1'b1, `OFS_TIMER_CONTROL, 32'h7c);
        apb(1'b1, `OFS_MODULE_CONTROL, 32'h2c);
        wait_rises(3);
        check({per_len, hi_len}, {16'd16, 16'd10});
        wait_rises(1);
        apb(1'b1, `OFS_DUTY_HIGH, 32'h1);
        apb(1'b1, `OFS_DUTY_SHADOW, 32'h55);
        rdc(`OFS_DUTY_SHADOW, 32'h2);
        wait_rises(2);
        rdc(`OFS_DUTY_SHADOW, 32'h1);
        check(hi_len, 16'd6);
        for (i = 0; i < 3; i++) begin
            apb(1'b1, `OFS_TIMER_CONTROL, 32'h4 | i);
            wait_rises(3);
            check({per_len, hi_len}, {16'd16 << (2 * i), 16'd6 << (2 * i)});
        end
        apb(1'b1, `OFS_TIMER_CONTROL, 32'h4);
        apb(1'b1, `OFS_MODULE_CONTROL, 32'h2e);
        wait_rises(3);
        check(hi_len, 16'd10);
        apb(1'b1, `OFS_MODULE_CONTROL, 32'hac);
        wait_rises(2);
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            check({pins.b_oe, pins.b}, {1'b1, ~pins.a});
        end
        apb(1'b1, `OFS_MODULE_CONTROL, 32'h0c);
        apb(1'b1, `OFS_DUTY_HIGH, 32'h0);
        repeat (40) @(posedge clk);
        c1 = {24'h0, rises};
        repeat (40) @(posedge clk);
        check({24'h0, rises}, c1);
        apb(1'b1, `OFS_DUTY_HIGH, 32'hff);
        repeat (40) @(posedge clk);
        for (i = 0; i < 4; i++) begin
            repeat (8) @(posedge clk);
            check(lvl_a, 1'b1);
        end
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, `OFS_TIMER_COUNT, 32'h0);
        c1 = rd;
        repeat (20) @(posedge clk);
        rdc(`OFS_TIMER_COUNT, c1);
        check(lvl_a, 1'b1);
        sleep <= 1'b0;
        repeat (8) @(posedge clk);
        apb(1'b0, `OFS_TIMER_COUNT, 32'h0);
        check(rd != c1, 1'b1);
        apb(1'b1, `OFS_MODULE_CONTROL, 32'h0);
        repeat (3) @(posedge clk);
        check({pins.a_oe, lvl_a, lvl_b}, 3'b000);
        apb(1'b1, `OFS_TIMER_CONTROL, 32'h0);
        apb(1'b1, `OFS_STATUS, 32'h1);
        rdc(`OFS_STATUS, 32'h0);
        wrap_up;
    end
endmodule : timer_based_pwm_unit_test
